/* File: adc_clock_reset_overflow_ctrl.sv */
// Purpose: Clock ratio, reset start-up and overflow alarm control
// Assumes: clk_sys is the master clock; rst_n is the device reset pin
// Notes:   Analogue path and control port protocol live elsewhere
`timescale 1ns/1ps
module adc_clock_reset_overflow_ctrl #(
    parameter int STARTUP_CYCLES = adc_ctrl_pkg::STARTUP_CYCLES,
    parameter int OVF_TIMEOUT    = adc_ctrl_pkg::OVF_TIMEOUT
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [1:0]  rate_select_pin,
    input  wire logic [1:0]  format_select_pin,
    input  wire logic [2:0]  divider_select_pin,
    input  wire logic        register_mode_enable,
    input  wire logic [1:0]  rate_select_reg,
    input  wire logic [1:0]  format_select_reg,
    input  wire logic [2:0]  divider_select_reg,
    input  wire logic        clocks_static,
    input  wire logic [7:0]  channel_over_range,
    input  wire logic        frame_sync_in,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic      [7:0]  channel_irq,
    output logic             overflow_alarm_pin_o,
    output logic             overflow_alarm_pin_oe,
    output logic             audio_enable,
    output logic             power_down,
    output logic             is_master,
    output logic             config_legal,
    output logic      [10:0] mclk_per_frame,
    output logic      [8:0]  bits_per_frame,
    output logic      [2:0]  tdm_slot,
    output logic      [4:0]  tdm_bit
);
    // Captured configuration
    logic [1:0]               rate_reg;
    logic [1:0]               rate_next;
    logic [1:0]               fmt_reg;
    logic [1:0]               fmt_next;
    logic [2:0]               div_reg;
    logic [2:0]               div_next;
    logic                     capture_reg;
    logic                     capture_next;
    adc_ctrl_pkg::run_state_t state_reg;
    adc_ctrl_pkg::run_state_t state_next;
    logic [31:0]              wait_reg;
    logic [31:0]              wait_next;

    // Configuration pin synchronisers
    logic [1:0]               rate_meta_reg;
    logic [1:0]               rate_sync_reg;
    logic [1:0]               fmt_meta_reg;
    logic [1:0]               fmt_sync_reg;
    logic [2:0]               div_meta_reg;
    logic [2:0]               div_sync_reg;

    // Overflow registers
    logic [7:0]               status_reg;
    logic [7:0]               status_next;
    logic [7:0]               mask_reg;
    logic [7:0]               mask_next;

    // Frame sync synchroniser and slot counter
    logic                     fs_meta_reg;
    logic                     fs_sync_reg;
    logic                     fs_prev_reg;
    logic [7:0]               bitpos_reg;
    logic [7:0]               bitpos_next;
    logic [7:0]               ovr_meta_reg;
    logic [7:0]               ovr_sync_reg;

    logic [10:0] ratio;
    logic [8:0]  bits;
    logic        legal;
    logic        fs_rise;
    logic        alarm_active;

    // Master/slave and TDM ratio tables
    always_comb begin
        ratio = adc_ctrl_pkg::RATIO_NONE;
        bits  = (fmt_reg == adc_ctrl_pkg::FMT_TDM) ? adc_ctrl_pkg::BITS_TDM
                                                   : adc_ctrl_pkg::BITS_TWO_CH;
        legal = 1'b1;
        case (rate_reg)
            adc_ctrl_pkg::RATE_SINGLE: begin
                case (div_reg)
                    adc_ctrl_pkg::DIV_4:   ratio = adc_ctrl_pkg::RATIO_1024;
                    adc_ctrl_pkg::DIV_3:   ratio = adc_ctrl_pkg::RATIO_768;
                    adc_ctrl_pkg::DIV_2:   ratio = adc_ctrl_pkg::RATIO_512;
                    adc_ctrl_pkg::DIV_1P5: ratio = adc_ctrl_pkg::RATIO_384;
                    adc_ctrl_pkg::DIV_1:   ratio = adc_ctrl_pkg::RATIO_256;
                    default:               legal = 1'b0;
                endcase
            end
            adc_ctrl_pkg::RATE_DOUBLE: begin
                case (div_reg)
                    adc_ctrl_pkg::DIV_4:   ratio = adc_ctrl_pkg::RATIO_512;
                    adc_ctrl_pkg::DIV_3:   ratio = adc_ctrl_pkg::RATIO_384;
                    adc_ctrl_pkg::DIV_2:   ratio = adc_ctrl_pkg::RATIO_256;
                    adc_ctrl_pkg::DIV_1P5: ratio = adc_ctrl_pkg::RATIO_192;
                    adc_ctrl_pkg::DIV_1:   ratio = adc_ctrl_pkg::RATIO_128;
                    default:               legal = 1'b0;
                endcase
                // TDM master cannot reach the smaller dividers
                if (fmt_reg == adc_ctrl_pkg::FMT_TDM
                    && div_reg > adc_ctrl_pkg::DIV_2) begin
                    legal = 1'b0;
                end
            end
            adc_ctrl_pkg::RATE_QUAD: begin
                case (div_reg)
                    adc_ctrl_pkg::DIV_4:   ratio = adc_ctrl_pkg::RATIO_256;
                    adc_ctrl_pkg::DIV_3:   ratio = adc_ctrl_pkg::RATIO_192;
                    adc_ctrl_pkg::DIV_2:   ratio = adc_ctrl_pkg::RATIO_128;
                    adc_ctrl_pkg::DIV_1P5: ratio = adc_ctrl_pkg::RATIO_96;
                    adc_ctrl_pkg::DIV_1:   ratio = adc_ctrl_pkg::RATIO_64;
                    default:               legal = 1'b0;
                endcase
                if (fmt_reg == adc_ctrl_pkg::FMT_TDM
                    && div_reg != adc_ctrl_pkg::DIV_4) begin
                    legal = 1'b0;
                end
            end
            adc_ctrl_pkg::RATE_SLAVE: begin
                // Slave: ratio set by external master, all dividers usable
                ratio = adc_ctrl_pkg::RATIO_NONE;
                legal = (div_reg <= adc_ctrl_pkg::DIV_1);
            end
            default: legal = 1'b0;
        endcase
        if (fmt_reg > adc_ctrl_pkg::FMT_TDM) begin
            legal = 1'b0;
        end
    end

    // Configuration capture
    always_comb begin
        rate_next = rate_reg;
        fmt_next  = fmt_reg;
        div_next  = div_reg;
        if (capture_reg) begin
            // Straps sampled once; later pin changes wait for a reset
            rate_next = rate_sync_reg;
            fmt_next  = fmt_sync_reg;
            div_next  = div_sync_reg;
        end
        if (register_mode_enable) begin
            // Register mode overrides the pins
            rate_next = rate_select_reg;
            fmt_next  = format_select_reg;
            div_next  = divider_select_reg;
        end
    end

    // Start-up sequence
    always_comb begin
        capture_next = 1'b0;
        state_next   = state_reg;
        wait_next    = wait_reg;
        case (state_reg)
            adc_ctrl_pkg::ST_OFF: begin
                capture_next = 1'b1;
                state_next   = adc_ctrl_pkg::ST_WAIT;
                wait_next    = 32'(STARTUP_CYCLES - 2);
            end
            adc_ctrl_pkg::ST_WAIT: begin
                if (wait_reg == 32'h0000_0000) begin
                    state_next = adc_ctrl_pkg::ST_RUN;
                end else begin
                    wait_next = wait_reg - 32'h0000_0001;
                end
            end
            adc_ctrl_pkg::ST_RUN: state_next = adc_ctrl_pkg::ST_RUN;
            default: state_next = adc_ctrl_pkg::ST_OFF;
        endcase
    end

    // Overflow status and mask
    always_comb begin
        mask_next   = mask_reg;
        status_next = status_reg;
        if (reg_wr && register_mode_enable
            && reg_addr == adc_ctrl_pkg::OVF_MASK_ADDR) begin
            mask_next = reg_wdata;
        end
        // Read clears; new events win over the clear
        if (reg_rd && reg_addr == adc_ctrl_pkg::OVF_STATUS_ADDR) begin
            status_next = 8'h00;
        end
        status_next = status_next | ovr_sync_reg;
    end

    // TDM slot tracking from frame sync rise
    assign fs_rise = fs_sync_reg && !fs_prev_reg;
    always_comb begin
        bitpos_next = bitpos_reg + 8'h01;
        if (fs_rise) begin
            bitpos_next = 8'h00;
        end
    end

    // Pin synchronisers have no reset so straps are settled at release
    always_ff @(posedge clk_sys) begin
        rate_meta_reg <= rate_select_pin;
        rate_sync_reg <= rate_meta_reg;
        fmt_meta_reg  <= format_select_pin;
        fmt_sync_reg  <= fmt_meta_reg;
        div_meta_reg  <= divider_select_pin;
        div_sync_reg  <= div_meta_reg;
    end

    // Configuration and start-up state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rate_reg    <= adc_ctrl_pkg::RATE_SINGLE;
            fmt_reg     <= adc_ctrl_pkg::FMT_LEFT;
            div_reg     <= adc_ctrl_pkg::DIV_4;
            capture_reg <= 1'b0;
            state_reg   <= adc_ctrl_pkg::ST_OFF;
            wait_reg    <= 32'h0000_0000;
        end else begin
            rate_reg    <= rate_next;
            fmt_reg     <= fmt_next;
            div_reg     <= div_next;
            capture_reg <= capture_next;
            state_reg   <= state_next;
            wait_reg    <= wait_next;
        end
    end

    // Overflow status and mask
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 8'h00;
            mask_reg   <= 8'h00;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
        end
    end

    // Event synchronisers and slot counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fs_meta_reg  <= 1'b0;
            fs_sync_reg  <= 1'b0;
            fs_prev_reg  <= 1'b0;
            bitpos_reg   <= 8'h00;
            ovr_meta_reg <= 8'h00;
            ovr_sync_reg <= 8'h00;
        end else begin
            fs_meta_reg  <= frame_sync_in;
            fs_sync_reg  <= fs_meta_reg;
            fs_prev_reg  <= fs_sync_reg;
            bitpos_reg   <= bitpos_next;
            ovr_meta_reg <= channel_over_range;
            ovr_sync_reg <= ovr_meta_reg;
        end
    end

    overflow_timer #(
        .TIMEOUT (OVF_TIMEOUT)
    ) u_overflow_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .trigger (|ovr_sync_reg),
        .active  (alarm_active)
    );

    // Pin mode only; open drain drives low while alarm active
    assign overflow_alarm_pin_o  = 1'b0;
    assign overflow_alarm_pin_oe = alarm_active
                                   && !register_mode_enable;
    assign channel_irq  = status_reg & mask_reg;
    assign reg_rdata    = (reg_addr == adc_ctrl_pkg::OVF_STATUS_ADDR)
                          ? status_reg
                          : (reg_addr == adc_ctrl_pkg::OVF_MASK_ADDR)
                          ? mask_reg : 8'h00;
    assign audio_enable = (state_reg == adc_ctrl_pkg::ST_RUN);
    // Reset with static clocks powers everything down
    assign power_down   = !rst_n && clocks_static;
    assign is_master    = (rate_reg != adc_ctrl_pkg::RATE_SLAVE);
    assign config_legal = legal;
    assign mclk_per_frame = ratio;
    assign bits_per_frame = bits;
    assign tdm_slot     = bitpos_reg[7:5];
    assign tdm_bit      = bitpos_reg[4:0];
endmodule : adc_clock_reset_overflow_ctrl

/* File: adc_ctrl_asserts.sv */
// Purpose: Port checks for clock ratio, start-up and overflow alarm
// Assumes: One clock domain, rst_n async active low
// Notes:   Alarm windows allow for the input synchroniser
`timescale 1ns/1ps
module adc_ctrl_asserts #(
    parameter int STARTUP_CYCLES = 524288,
    parameter int OVF_TIMEOUT    = 8192
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        register_mode_enable,
    input wire logic [7:0]  channel_over_range,
    input wire logic        frame_sync_in,
    input wire logic        overflow_alarm_pin_oe,
    input wire logic        audio_enable,
    input wire logic        is_master,
    input wire logic        config_legal,
    input wire logic [10:0] mclk_per_frame,
    input wire logic [8:0]  bits_per_frame,
    input wire logic [2:0]  tdm_slot,
    input wire logic [4:0]  tdm_bit
);
    logic [19:0] up_reg, up_next;
    logic [15:0] quiet_reg, quiet_next;
    logic [7:0]  pos;
    assign pos = {tdm_slot, tdm_bit};
    // Saturate so long idle spans never wrap
    always_comb begin
        up_next    = up_reg + {19'h0_0000, ~&up_reg};
        quiet_next = (|channel_over_range) ? 16'h0000
                   : quiet_reg + {15'h0000, ~&quiet_reg};
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_reg    <= 20'h0_0000;
            quiet_reg <= 16'hffff;
        end else begin
            up_reg    <= up_next;
            quiet_reg <= quiet_next;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_alarm_rises: assert property (
        !register_mode_enable && |channel_over_range |-> ##3
        (overflow_alarm_pin_oe || register_mode_enable))
        else $error("alarm not raised after over-range");
    a_reg_mode_quiet: assert property (
        register_mode_enable |-> !overflow_alarm_pin_oe)
        else $error("alarm driven in register mode");
    a_alarm_holds: assert property (
        !register_mode_enable && quiet_reg >= 16'h0003
        && quiet_reg <= 16'(OVF_TIMEOUT) |-> overflow_alarm_pin_oe)
        else $error("alarm released before timeout");
    a_alarm_expires: assert property (
        quiet_reg > 16'(OVF_TIMEOUT + 3) |-> !overflow_alarm_pin_oe)
        else $error("alarm held past timeout");
    a_start_latency: assert property (
        audio_enable == (up_reg >= 20'(STARTUP_CYCLES)))
        else $error("audio start not at start-up count");
    a_slave_ratio: assert property (
        !is_master |-> mclk_per_frame == adc_ctrl_pkg::RATIO_NONE)
        else $error("slave reports a master ratio");
    a_ratio_bits: assert property (
        is_master && config_legal |->
        mclk_per_frame >= {2'b00, bits_per_frame})
        else $error("master ratio below bit clocks per frame");
    a_slot_step: assert property (
        (up_reg > 20'h0_0004 && $stable(frame_sync_in)) [*8] |->
        pos == $past(pos) + 8'h01)
        else $error("bit position did not advance");
endmodule : adc_ctrl_asserts

bind adc_clock_reset_overflow_ctrl adc_ctrl_asserts #(
    .STARTUP_CYCLES(STARTUP_CYCLES),
    .OVF_TIMEOUT   (OVF_TIMEOUT)
) i_chk (
    .clk_sys, .rst_n, .register_mode_enable, .channel_over_range,
    .frame_sync_in, .overflow_alarm_pin_oe, .audio_enable, .is_master,
    .config_legal, .mclk_per_frame, .bits_per_frame, .tdm_slot, .tdm_bit
);

/* File: adc_ctrl_pkg.sv */
// Purpose: Shared constants for converter clocking, reset and overflow control
// Assumes: Master clock domain clk_sys at 40 MHz
// Notes:   Ratios are master clocks per frame, bit clocks per frame
package adc_ctrl_pkg;

    localparam int CLK_HZ = 40_000_000;

    // Rate select encoding
    localparam logic [1:0] RATE_SINGLE = 2'h0;
    localparam logic [1:0] RATE_DOUBLE = 2'h1;
    localparam logic [1:0] RATE_QUAD   = 2'h2;
    localparam logic [1:0] RATE_SLAVE  = 2'h3;

    // Format select encoding
    localparam logic [1:0] FMT_LEFT = 2'h0;
    localparam logic [1:0] FMT_I2S  = 2'h1;
    localparam logic [1:0] FMT_TDM  = 2'h2;

    // Divider select: 0 div4, 1 div3, 2 div2, 3 div1.5, 4 div1
    localparam logic [2:0] DIV_4   = 3'h0;
    localparam logic [2:0] DIV_3   = 3'h1;
    localparam logic [2:0] DIV_2   = 3'h2;
    localparam logic [2:0] DIV_1P5 = 3'h3;
    localparam logic [2:0] DIV_1   = 3'h4;

    localparam logic [10:0] RATIO_1024 = 11'h400;
    localparam logic [10:0] RATIO_768  = 11'h300;
    localparam logic [10:0] RATIO_512  = 11'h200;
    localparam logic [10:0] RATIO_384  = 11'h180;
    localparam logic [10:0] RATIO_256  = 11'h100;
    localparam logic [10:0] RATIO_192  = 11'h0C0;
    localparam logic [10:0] RATIO_128  = 11'h080;
    localparam logic [10:0] RATIO_96   = 11'h060;
    localparam logic [10:0] RATIO_64   = 11'h040;
    localparam logic [10:0] RATIO_NONE = 11'h000;

    localparam logic [8:0] BITS_TWO_CH = 9'h040;
    localparam logic [8:0] BITS_TDM    = 9'h100;
    localparam logic [5:0] SLOT_BITS   = 6'h20;
    localparam int         NUM_CH      = 8;

    localparam int STARTUP_CYCLES = 524288;
    localparam int OVF_TIMEOUT    = 8192;

    // Register map
    localparam logic [7:0] OVF_STATUS_ADDR = 8'h02;
    localparam logic [7:0] OVF_MASK_ADDR   = 8'h03;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAIT,
        ST_RUN
    } run_state_t;

endpackage : adc_ctrl_pkg

/* File: adc_frame_source.sv */
// Purpose: Far-side frame clock source for slave operation
// Assumes: Frame derived from clk_sys at a fixed division
// Notes:   Line stays low while stopped
`timescale 1ns/1ps
module adc_frame_source #(
    parameter int PERIOD = 256
) (
    input  wire logic clk_sys,
    input  wire logic run,
    output logic      frame_sync
);
    int phase;
    initial frame_sync = 1'b0;
    // Fixed period, ratio never changes in a run
    always @(posedge clk_sys) begin
        if (!run) begin
            phase <= 0;
            frame_sync <= 1'b0;
        end else begin
            phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
            frame_sync <= (phase < PERIOD / 2);
        end
    end
endmodule : adc_frame_source

/* File: overflow_timer.sv */
// Purpose: Retriggerable hold timer for the overflow alarm
// Assumes: Same clock as the caller
// Notes:   Restart wins over expiry in the same cycle
`timescale 1ns/1ps
module overflow_timer #(
    parameter int TIMEOUT = 8192
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic trigger,
    output logic      active
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic        active_reg;
    logic        active_next;

    always_comb begin
        count_next  = count_reg;
        active_next = active_reg;
        if (trigger) begin
            count_next  = 32'(TIMEOUT);
            active_next = 1'b1;
        end else if (active_reg) begin
            if (count_reg <= 32'h0000_0001) begin
                count_next  = 32'h0000_0000;
                active_next = 1'b0;
            end else begin
                count_next = count_reg - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg  <= 32'h0000_0000;
            active_reg <= 1'b0;
        end else begin
            count_reg  <= count_next;
            active_reg <= active_next;
        end
    end

    assign active = active_reg;
endmodule : overflow_timer

/* File: tb_top.sv */
// Purpose: Self-checking bench for converter clock and overflow control
// Assumes: Start-up and alarm counts shortened for simulation
// Notes:   Frame sync comes from the far-side model
`timescale 1ns/1ps
module tb_top;
    localparam int START = 20;
    localparam int TOUT  = 16;
    logic        clk_sys, rst_n, register_mode_enable, clocks_static;
    logic        frame_sync_in, reg_wr, reg_rd, fs_run;
    logic [1:0]  rate_select_pin, format_select_pin;
    logic [1:0]  rate_select_reg, format_select_reg;
    logic [2:0]  divider_select_pin, divider_select_reg;
    logic [7:0]  channel_over_range, reg_addr, reg_wdata;
    logic [7:0]  reg_rdata, channel_irq;
    logic        overflow_alarm_pin_o, overflow_alarm_pin_oe;
    logic        audio_enable, power_down, is_master, config_legal;
    logic [10:0] mclk_per_frame;
    logic [8:0]  bits_per_frame;
    logic [2:0]  tdm_slot;
    logic [4:0]  tdm_bit;
    int          bad_count, num_checks;
    wire         alarm_line;
    // Open-drain line with pull-up
    assign alarm_line = overflow_alarm_pin_oe ? overflow_alarm_pin_o : 1'b1;

    adc_clock_reset_overflow_ctrl #(
        .STARTUP_CYCLES(START),
        .OVF_TIMEOUT   (TOUT)
    ) i_dut (
        .clk_sys, .rst_n, .rate_select_pin, .format_select_pin,
        .divider_select_pin, .register_mode_enable, .rate_select_reg,
        .format_select_reg, .divider_select_reg, .clocks_static,
        .channel_over_range, .frame_sync_in, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .channel_irq, .overflow_alarm_pin_o,
        .overflow_alarm_pin_oe, .audio_enable, .power_down, .is_master,
        .config_legal, .mclk_per_frame, .bits_per_frame, .tdm_slot,
        .tdm_bit
    );
    adc_frame_source #(.PERIOD(256)) i_fs (
        .clk_sys, .run(fs_run), .frame_sync(frame_sync_in)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic look();
        @(negedge clk_sys);
    endtask : look
    task automatic pulse_reset();
        rst_n <= 1'b0;
        cyc(1);
        rst_n <= 1'b1;
        cyc(4);
    endtask : pulse_reset
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        look();
        chk(reg_rdata, exp);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : reg_read

    task automatic t_power_down();
        cyc(8);
        look();
        chk(power_down, 1'b1);
        @(posedge clk_sys);
        clocks_static <= 1'b0;
        look();
        chk(power_down, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(START - 1);
        look();
        chk(audio_enable, 1'b0);
        cyc(1);
        look();
        chk(audio_enable, 1'b1);
        $display("done power_down");
    endtask : t_power_down

    task automatic t_ratios();
        logic [10:0] base, exp_r;
        logic [8:0]  exp_b;
        logic        legal;
        for (int r = 0; r < 4; r++) begin
            for (int f = 0; f < 4; f++) begin
                for (int d = 0; d < 6; d++) begin
                    @(posedge clk_sys);
                    rate_select_pin <= 2'(r);
                    format_select_pin <= 2'(f);
                    divider_select_pin <= 3'(d);
                    pulse_reset();
                    look();
                    base = (r == 0) ? 11'h400 : (r == 1) ? 11'h200 : 11'h100;
                    case (d)
                        1: exp_r = (base >> 2) * 3;
                        2: exp_r = base >> 1;
                        3: exp_r = (base >> 3) * 3;
                        4: exp_r = base >> 2;
                        default: exp_r = base;
                    endcase
                    if (r == 3) exp_r = adc_ctrl_pkg::RATIO_NONE;
                    exp_b = (f == 2) ? 9'h100 : 9'h040;
                    legal = (f != 3) && (d < 5);
                    if (f == 2 && r == 1 && d > 2) legal = 1'b0;
                    if (f == 2 && r == 2 && d > 0) legal = 1'b0;
                    chk(config_legal, legal);
                    chk(is_master, r != 3);
                    if (legal) begin
                        chk(mclk_per_frame, exp_r);
                        chk(bits_per_frame, exp_b);
                    end
                end
            end
        end
        $display("done ratios");
    endtask : t_ratios

    task automatic t_capture();
        @(posedge clk_sys);
        {rate_select_pin, format_select_pin, divider_select_pin} <= '0;
        pulse_reset();
        @(posedge clk_sys);
        divider_select_pin <= adc_ctrl_pkg::DIV_1;
        format_select_pin <= adc_ctrl_pkg::FMT_TDM;
        cyc(3);
        look();
        chk(mclk_per_frame, 11'h400);
        chk(bits_per_frame, 9'h040);
        $display("done capture");
    endtask : t_capture

    task automatic t_overflow();
        @(posedge clk_sys);
        channel_over_range <= 8'h01;
        @(posedge clk_sys);
        channel_over_range <= 8'h00;
        cyc(1);
        look();
        chk(alarm_line, 1'b1);
        cyc(1);
        look();
        chk(alarm_line, 1'b0);
        cyc(5);
        channel_over_range <= 8'h80;
        @(posedge clk_sys);
        channel_over_range <= 8'h00;
        cyc(TOUT);
        look();
        chk(alarm_line, 1'b0);
        cyc(1);
        look();
        chk(alarm_line, 1'b0);
        cyc(1);
        look();
        chk(alarm_line, 1'b1);
        $display("done overflow");
    endtask : t_overflow

    task automatic t_frame();
        @(posedge clk_sys);
        fs_run <= 1'b1;
        cyc(4);
        look();
        chk({tdm_slot, tdm_bit}, 8'h00);
        cyc(32);
        look();
        chk({tdm_slot, tdm_bit}, 8'h20);
        @(posedge clk_sys);
        fs_run <= 1'b0;
        $display("done frame");
    endtask : t_frame

    task automatic t_register();
        @(posedge clk_sys);
        register_mode_enable <= 1'b1;
        rate_select_reg <= adc_ctrl_pkg::RATE_SLAVE;
        format_select_reg <= adc_ctrl_pkg::FMT_TDM;
        divider_select_reg <= adc_ctrl_pkg::DIV_1;
        reg_write(adc_ctrl_pkg::OVF_MASK_ADDR, 8'h05);
        reg_write(adc_ctrl_pkg::OVF_STATUS_ADDR, 8'hff);
        reg_read(adc_ctrl_pkg::OVF_STATUS_ADDR, 8'h81);
        reg_read(adc_ctrl_pkg::OVF_MASK_ADDR, 8'h05);
        channel_over_range <= 8'h07;
        @(posedge clk_sys);
        channel_over_range <= 8'h00;
        cyc(6);
        look();
        chk(alarm_line, 1'b1);
        chk(channel_irq, 8'h05);
        chk(bits_per_frame, 9'h100);
        reg_read(adc_ctrl_pkg::OVF_STATUS_ADDR, 8'h07);
        cyc(2);
        look();
        chk(channel_irq, 8'h00);
        reg_read(8'h7f, 8'h00);
        $display("done register");
    endtask : t_register

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        bad_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        clocks_static = 1'b1;
        fs_run = 1'b0;
        register_mode_enable = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {rate_select_pin, format_select_pin, divider_select_pin} = '0;
        {rate_select_reg, format_select_reg, divider_select_reg} = '0;
        channel_over_range = 8'h00;
        t_power_down();
        t_ratios();
        t_capture();
        t_overflow();
        t_frame();
        t_register();
        complete_run();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        #(25 * 20000);
        bad_count++;
        $display("ERROR t=%0t watchdog got=%h exp=%h", $time, 0, 1);
        complete_run();
    end
endmodule : tb_top
